/* File: include/amc_pkg.sv */
`default_nettype none
package amc_pkg;
	// ****************************************************
	// Bus and register map
	// ****************************************************
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam logic [15:0] OFS_RISE = 16'hFF48;
	localparam logic [15:0] OFS_FALL = 16'hFF49;
	localparam logic [15:0] OFS_MODE = 16'hFF80;
	localparam logic [15:0] OFS_CHAN = 16'hFF81;
	localparam logic [15:0] OFS_RES_LO = 16'hFF82;
	localparam logic [15:0] OFS_RES_HI = 16'hFF83;
	localparam logic [15:0] OFS_STATUS = 16'hFF84;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [3:0] RST_CHAN = 4'h0;
	localparam logic [5:0] RST_EDGE = 6'h00;
	localparam logic [9:0] RST_RESULT = 10'h000;

	// ****************************************************
	// Field positions
	// ****************************************************
	localparam int MODE_ENABLE_BIT = 7;
	localparam int MODE_SRC_BIT = 6;
	localparam int MODE_TIME_HI = 5;
	localparam int MODE_TIME_LO = 3;
	localparam int MODE_TRIG_RISE_BIT = 2;
	localparam int MODE_TRIG_FALL_BIT = 1;
	localparam int MODE_BOOST_BIT = 0;
	localparam int CHAN_W = 4;
	localparam int EXT_IRQ_NUM = 6;
	localparam int SHARED_PINS = 8;
	localparam int RES_W = 10;
	localparam int RES_PAD = 6;

	// ****************************************************
	// Conversion timing
	// ****************************************************
	localparam logic [2:0] TIME_144 = 3'h0;
	localparam logic [2:0] TIME_576 = 3'h4;
	localparam logic [2:0] TIME_480 = 3'h5;
	localparam logic [2:0] TIME_384 = 3'h6;
	localparam int CONV_CLK_144 = 144;
	localparam int CONV_CLK_576 = 576;
	localparam int CONV_CLK_480 = 480;
	localparam int CONV_CLK_384 = 384;
	localparam int SAMPLE_STEPS = 2;
	localparam int CONV_STEPS = SAMPLE_STEPS + RES_W;
	localparam int STEP_W = 8;
	localparam logic [7:0] STEP_144 = 8'(CONV_CLK_144 / CONV_STEPS);
	localparam logic [7:0] STEP_576 = 8'(CONV_CLK_576 / CONV_STEPS);
	localparam logic [7:0] STEP_480 = 8'(CONV_CLK_480 / CONV_STEPS);
	localparam logic [7:0] STEP_384 = 8'(CONV_CLK_384 / CONV_STEPS);

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_DECIDE} amc_seq_e;
endpackage
`default_nettype wire

/* File: core/amc_edge_sync.sv */
`default_nettype none
module amc_edge_sync #(
	parameter int WIDTH = 7
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Raw pins and edge selection
	input wire logic [WIDTH-1:0] raw,
	input wire logic [WIDTH-1:0] rise_en,
	input wire logic [WIDTH-1:0] fall_en,
	// One-cycle edge pulses
	output logic [WIDTH-1:0] pulse
);
	import amc_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
		logic [WIDTH-1:0] prev;
		logic [WIDTH-1:0] pulse;
	} amc_edge_s;

	amc_edge_s cur;
	amc_edge_s next_cur;

	initial begin
		if (WIDTH < 1) $error("amc_edge_sync: WIDTH must be positive");
	end

	always_comb begin
		next_cur = cur;
		next_cur.meta = raw;
		next_cur.sync = cur.meta;
		next_cur.prev = cur.sync;
		next_cur.pulse = (cur.sync & ~cur.prev & rise_en) |
			(~cur.sync & cur.prev & fall_en); // R5 R16
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign pulse = cur.pulse;
endmodule
`default_nettype wire

/* File: core/amc_sar_seq.sv */
`default_nettype none
module amc_sar_seq (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Control
	input wire logic start,
	input wire logic abort,
	input wire logic [amc_pkg::STEP_W-1:0] step_len,
	// Analog side
	input wire logic comparator_high,
	output logic sampling,
	output logic [amc_pkg::RES_W-1:0] trial,
	// Status and result
	output logic busy,
	output logic done,
	output logic [amc_pkg::RES_W-1:0] result
);
	import amc_pkg::*;

	typedef struct packed {
		amc_seq_e state;
		logic [STEP_W-1:0] cnt;
		logic [3:0] bitn;
		logic [RES_W-1:0] trial;
		logic [RES_W-1:0] result;
		logic done;
		logic cmp_meta;
		logic cmp_sync;
	} amc_sar_s;

	amc_sar_s cur;
	amc_sar_s next_cur;

	always_comb begin
		logic [RES_W-1:0] tmp;
		tmp = cur.trial;
		next_cur = cur;
		next_cur.done = 1'b0;
		next_cur.cmp_meta = comparator_high;
		next_cur.cmp_sync = cur.cmp_meta;
		if (abort) begin
			next_cur.state = SEQ_IDLE;
			next_cur.trial = '0;
		end else begin
			unique case (cur.state)
				SEQ_IDLE: begin
					if (start) begin
						next_cur.state = SEQ_SAMPLE;
						next_cur.cnt = STEP_W'((step_len << 1) - 8'h01);
						next_cur.trial = '0;
					end
				end
				SEQ_SAMPLE: begin
					if (cur.cnt == '0) begin
						next_cur.state = SEQ_DECIDE;
						next_cur.bitn = 4'(RES_W - 1);
						next_cur.trial = 10'h200;
						next_cur.cnt = step_len - 8'h01;
					end else begin
						next_cur.cnt = cur.cnt - 8'h01;
					end
				end
				SEQ_DECIDE: begin
					// Each trial stands a full step, so the two sync
					// cycles on the comparator never cut a decision short
					if (cur.cnt == '0) begin
						if (!cur.cmp_sync) tmp[cur.bitn] = 1'b0; // R20
						if (cur.bitn == 4'h0) begin
							next_cur.result = tmp; // R19
							next_cur.done = 1'b1; // R19
							next_cur.state = SEQ_IDLE;
						end else begin
							tmp[cur.bitn - 4'h1] = 1'b1; // R20
							next_cur.bitn = cur.bitn - 4'h1;
							next_cur.cnt = step_len - 8'h01;
						end
						next_cur.trial = tmp;
					end else begin
						next_cur.cnt = cur.cnt - 8'h01;
					end
				end
				default: next_cur.state = SEQ_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cur <= '{state: SEQ_IDLE, result: RST_RESULT, default: '0};
		end else begin
			cur <= next_cur;
		end
	end

	assign busy = (cur.state != SEQ_IDLE);
	assign sampling = (cur.state == SEQ_SAMPLE);
	assign trial = cur.trial;
	assign done = cur.done;
	assign result = cur.result;
endmodule
`default_nettype wire

/* File: core/amc_top.sv */
// Notes on behaviour
// (R1) Mode bit 7 enables conversion; clearing it stops activity; resets zero.
// (R2) Mode bit 6 picks software start (0) or external trigger (1).
// (R3) Mode bits 5:3 set conversion length: 144, 576, 480 or 384 clocks.
// (R4) Software avoids time codes 001, 010 and unlisted codes.
// (R5) Mode bits 2:1 pick trigger edge: none, falling, rising, both.
// (R6) Mode bit 0 runs the reference booster.
// (R7) Software turns the booster on before enabling conversion.
// (R8) Software waits 14 us between booster on and conversion enable.
// (R9) Software clears conversion enable before clearing booster enable.
// (R10) Software stops conversion before changing the time field.
// (R11) Channel select low four bits pick input 0 to 9; upper bits read 0.
// (R12) Channel select is written as a whole byte and resets to zero.
// (R13) Shared pins stay digital inputs except the selected channel.
// (R14) Software avoids reading the shared port during conversion.
// (R15) Rising and falling enable registers hold six bits, reset zero.
// (R16) Rising/falling pair per input selects none, fall, rise or both.
// (R17) Hardware start: one conversion per trigger edge; channel write aborts.
// (R18) Software start: repeats; channel write restarts on the new channel.
// (R19) Mode write with enable low stops at once; result and irq together.
// (R20) Sequencer counts the length and decides ten bits, MSB first.
//
// The address-and-strobe port was chosen for this implementation.
`default_nettype none
module amc_top (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [amc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [amc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [amc_pkg::DATA_W-1:0] reg_rdata,
	// Trigger and external interrupt pins
	input wire logic external_conv_trigger,
	input wire logic [amc_pkg::EXT_IRQ_NUM-1:0] ext_irq_input,
	output logic [amc_pkg::EXT_IRQ_NUM-1:0] ext_irq_edge,
	// Analog front end
	input wire logic comparator_high,
	output logic sample_enable,
	output logic [amc_pkg::RES_W-1:0] sar_trial,
	output logic booster_enable,
	output logic [amc_pkg::CHAN_W-1:0] channel_code,
	// Shared port pins
	output logic [amc_pkg::SHARED_PINS-1:0] digital_input_enable,
	// Conversion status
	output logic conversion_busy,
	output logic conversion_end_irq,
	output logic [amc_pkg::RES_W-1:0] conversion_result
);
	import amc_pkg::*;

	// ****************************************************
	// State
	// ****************************************************
	typedef struct packed {
		logic [DATA_W-1:0] mode;
		logic [CHAN_W-1:0] chan;
		logic [EXT_IRQ_NUM-1:0] rise;
		logic [EXT_IRQ_NUM-1:0] fall;
		logic [SHARED_PINS-1:0] din_en;
		logic [DATA_W-1:0] rdata;
	} amc_top_s;

	amc_top_s cur;
	amc_top_s next_cur;

	logic wr_mode;
	logic wr_chan;
	logic wr_rise;
	logic wr_fall;
	logic abort;
	logic start;
	logic sw_go;
	logic hw_go;
	logic conv_on;
	logic hw_start;
	logic [STEP_W-1:0] step_len;
	logic [EXT_IRQ_NUM:0] edge_pulse;
	logic seq_busy;
	logic seq_done;
	logic [RES_W-1:0] seq_result;

	// ****************************************************
	// Register decode
	// ****************************************************
	assign wr_mode = reg_write && (reg_addr == OFS_MODE);
	assign wr_chan = reg_write && (reg_addr == OFS_CHAN);
	assign wr_rise = reg_write && (reg_addr == OFS_RISE);
	assign wr_fall = reg_write && (reg_addr == OFS_FALL);

	assign conv_on = cur.mode[MODE_ENABLE_BIT]; // R1
	assign hw_start = cur.mode[MODE_SRC_BIT]; // R2

	// ****************************************************
	// Conversion length
	// ****************************************************
	// Forbidden codes fall back to the shortest setting, 144 clocks,
	// so a stray write never yields an undersized conversion
	always_comb begin
		unique case (cur.mode[MODE_TIME_HI:MODE_TIME_LO])
			TIME_144: step_len = STEP_144; // R3
			TIME_576: step_len = STEP_576; // R3
			TIME_480: step_len = STEP_480; // R3
			TIME_384: step_len = STEP_384; // R3
			default: step_len = STEP_144;
		endcase
	end

	// ****************************************************
	// Pin synchronisers and edge selection
	// ****************************************************
	amc_edge_sync #(
		.WIDTH(EXT_IRQ_NUM + 1)
	) u_edges (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.raw({external_conv_trigger, ext_irq_input}),
		.rise_en({cur.mode[MODE_TRIG_RISE_BIT], cur.rise}), // R5 R16
		.fall_en({cur.mode[MODE_TRIG_FALL_BIT], cur.fall}), // R5 R16
		.pulse(edge_pulse)
	);

	assign ext_irq_edge = edge_pulse[EXT_IRQ_NUM-1:0];

	// ****************************************************
	// Start and abort
	// ****************************************************
	// Any write to mode or channel sends the sequencer back to idle;
	// the start is held off for that cycle so the new settings apply
	assign abort = wr_mode || wr_chan; // R17 R18 R19
	// Software start relaunches in the cycle the result lands
	assign sw_go = conv_on && !hw_start && !seq_busy; // R18
	// Edges that arrive mid-conversion are dropped, not queued
	assign hw_go = conv_on && hw_start && !seq_busy &&
		edge_pulse[EXT_IRQ_NUM]; // R17
	assign start = (sw_go || hw_go) && !abort;

	amc_sar_seq u_seq (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.start(start),
		.abort(abort),
		.step_len(step_len),
		.comparator_high(comparator_high),
		.sampling(sample_enable),
		.trial(sar_trial),
		.busy(seq_busy),
		.done(seq_done),
		.result(seq_result)
	);

	// ****************************************************
	// Register file
	// ****************************************************
	always_comb begin
		next_cur = cur;
		if (wr_mode) begin
			next_cur.mode = reg_wdata; // R1 R2 R3 R5 R6
		end
		if (wr_chan) begin
			next_cur.chan = reg_wdata[CHAN_W-1:0]; // R11 R12
		end
		if (wr_rise) begin
			next_cur.rise = reg_wdata[EXT_IRQ_NUM-1:0]; // R15
		end
		if (wr_fall) begin
			next_cur.fall = reg_wdata[EXT_IRQ_NUM-1:0]; // R15
		end
		for (int i = 0; i < SHARED_PINS; i++) begin
			next_cur.din_en[i] = (next_cur.chan != CHAN_W'(i)); // R13
		end
		next_cur.rdata = '0;
		if (reg_read) begin
			unique case (reg_addr)
				OFS_MODE: next_cur.rdata = cur.mode;
				OFS_CHAN: next_cur.rdata = {4'h0, cur.chan}; // R11
				OFS_RISE: next_cur.rdata = {2'h0, cur.rise};
				OFS_FALL: next_cur.rdata = {2'h0, cur.fall};
				OFS_RES_LO: next_cur.rdata = {seq_result[1:0], 6'h00};
				OFS_RES_HI: next_cur.rdata = seq_result[RES_W-1:2];
				OFS_STATUS: next_cur.rdata = {7'h00, seq_busy};
				default: next_cur.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cur.mode <= RST_MODE; // R1
			cur.chan <= RST_CHAN; // R12
			cur.rise <= RST_EDGE; // R15
			cur.fall <= RST_EDGE; // R15
			cur.din_en <= 8'hFE;
			cur.rdata <= 8'h00;
		end else begin
			cur <= next_cur;
		end
	end

	// ****************************************************
	// Outputs
	// ****************************************************
	assign reg_rdata = cur.rdata;
	assign booster_enable = cur.mode[MODE_BOOST_BIT]; // R6
	assign channel_code = cur.chan;
	assign digital_input_enable = cur.din_en;
	assign conversion_busy = seq_busy;
	assign conversion_end_irq = seq_done; // R19
	assign conversion_result = seq_result;
endmodule
`default_nettype wire

/* File: tb/amc_checker_properties.sv */
`default_nettype none
module amc_checker (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [amc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [amc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [amc_pkg::DATA_W-1:0] reg_rdata,
	// Pins and converter outputs
	input wire logic [amc_pkg::EXT_IRQ_NUM-1:0] ext_irq_edge,
	input wire logic sample_enable,
	input wire logic [amc_pkg::RES_W-1:0] sar_trial,
	input wire logic booster_enable,
	input wire logic [amc_pkg::CHAN_W-1:0] channel_code,
	input wire logic [amc_pkg::SHARED_PINS-1:0] digital_input_enable,
	input wire logic conversion_busy,
	input wire logic conversion_end_irq,
	input wire logic [amc_pkg::RES_W-1:0] conversion_result
);
	timeunit 1ns;
	timeprecision 1ns;
	import amc_pkg::*;
	// ****************************************************
	// Shadow registers and run counter
	// ****************************************************
	logic [7:0] mode_sh;
	logic [5:0] rise_sh;
	logic [5:0] fall_sh;
	logic [9:0] cnt;
	logic [9:0] len;
	// Shadows follow every write, so disabling an input is checked too
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mode_sh <= 8'h00;
			rise_sh <= 6'h00;
			fall_sh <= 6'h00;
		end else if (reg_write && reg_addr == OFS_MODE) begin
			mode_sh <= reg_wdata;
		end else if (reg_write && reg_addr == OFS_RISE) begin
			rise_sh <= reg_wdata[5:0];
		end else if (reg_write && reg_addr == OFS_FALL) begin
			fall_sh <= reg_wdata[5:0];
		end
	end
	// Counter restarts whenever busy drops, so aborts never leak over
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !conversion_busy) cnt <= 10'h000;
		else cnt <= cnt + 10'h001;
	end
	always_comb begin
		case (mode_sh[5:3])
			TIME_576: len = 10'(CONV_CLK_576);
			TIME_480: len = 10'(CONV_CLK_480);
			TIME_384: len = 10'(CONV_CLK_384);
			default: len = 10'(CONV_CLK_144);
		endcase
	end
	// ****************************************************
	// Properties
	// ****************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_stop_write;
		reg_write && reg_addr == OFS_MODE && !reg_wdata[7];
	endsequence
	sequence s_hold_start;
		sample_enable ##1 (!sample_enable && conversion_busy);
	endsequence
	property p_chan_hi;
		$past(reg_read) && $past(reg_addr) == OFS_CHAN |-> reg_rdata[7:4] == 4'h0;
	endproperty
	a_chan_hi: assert property (p_chan_hi) else $error("channel upper bits");
	property p_din;
		$stable(channel_code)[*2] |->
			digital_input_enable == ~8'(9'h001 << channel_code);
	endproperty
	a_din: assert property (p_din) else $error("digital input enables");
	property p_boost;
		reg_write && reg_addr == OFS_MODE |=> booster_enable == $past(reg_wdata[0]);
	endproperty
	a_boost: assert property (p_boost) else $error("booster enable");
	property p_stop;
		s_stop_write |=> (!conversion_busy && !conversion_end_irq)[*3];
	endproperty
	a_stop: assert property (p_stop) else $error("stop write");
	property p_len;
		conversion_end_irq |-> cnt == len;
	endproperty
	a_len: assert property (p_len) else $error("conversion length");
	property p_res;
		!$stable(conversion_result) |-> conversion_end_irq;
	endproperty
	a_res: assert property (p_res) else $error("result without irq");
	property p_msb;
		s_hold_start |-> sar_trial == 10'h200;
	endproperty
	a_msb: assert property (p_msb) else $error("first trial");
	property p_edge;
		ext_irq_edge != 6'h00 |->
			(ext_irq_edge & ~$past(rise_sh | fall_sh)) == 6'h00;
	endproperty
	a_edge: assert property (p_edge) else $error("edge when disabled");
	property p_hw;
		conversion_end_irq && mode_sh[6] |=> !conversion_busy;
	endproperty
	a_hw: assert property (p_hw) else $error("hardware restart");
	property p_sw;
		conversion_end_irq && mode_sh[7:6] == 2'b10 |=> conversion_busy;
	endproperty
	a_sw: assert property (p_sw) else $error("software restart");
endmodule

bind amc_top amc_checker i_amc_checker (.sys_clk(sys_clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
	.reg_read(reg_read), .reg_rdata(reg_rdata), .ext_irq_edge(ext_irq_edge),
	.sample_enable(sample_enable), .sar_trial(sar_trial),
	.booster_enable(booster_enable), .channel_code(channel_code),
	.digital_input_enable(digital_input_enable),
	.conversion_busy(conversion_busy), .conversion_end_irq(conversion_end_irq),
	.conversion_result(conversion_result));
`default_nettype wire

/* File: tb/amc_analog_model.sv */
`default_nettype none
module amc_analog_model (
	// Clock
	input wire logic sys_clk,
	// Ideal channel levels as codes
	input wire logic [amc_pkg::RES_W-1:0] vin [10],
	// Converter side
	input wire logic sample_enable,
	input wire logic [amc_pkg::CHAN_W-1:0] channel_code,
	input wire logic [amc_pkg::RES_W-1:0] sar_trial,
	output logic comparator_high
);
	timeunit 1ns;
	timeprecision 1ns;
	import amc_pkg::*;
	logic [RES_W-1:0] held = '0;
	// Prohibited channels have no pin: the held level wanders
	always @(posedge sys_clk) begin
		if (sample_enable) held <= (channel_code < 4'hA) ? vin[channel_code] : ~held;
	end
	assign comparator_high = held >= sar_trial;
endmodule
`default_nettype wire

/* File: tb/tb_amc_top.sv */
`default_nettype none
module tb_amc_top;
	timeunit 1ns;
	timeprecision 1ns;
	import amc_pkg::*;
	logic sys_clk, rst_n, reg_write, reg_read, external_conv_trigger;
	logic sample_enable, booster_enable, comparator_high;
	logic conversion_busy, conversion_end_irq;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, d, digital_input_enable;
	logic [5:0] ext_irq_input, ext_irq_edge, seen;
	logic [9:0] sar_trial, conversion_result;
	logic [9:0] vin [10];
	logic [3:0] channel_code, ch;
	logic [11:0] e;
	logic [31:0] lfsr;
	logic [15:0] map [5] = '{OFS_RISE, OFS_FALL, OFS_MODE, OFS_CHAN, 16'hFF90};
	logic [2:0] tc [4] = '{TIME_144, TIME_576, TIME_480, TIME_384};
	int n_mismatch, tests_run, k, c;
	amc_top i_amc_top (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .external_conv_trigger(external_conv_trigger),
		.ext_irq_input(ext_irq_input), .ext_irq_edge(ext_irq_edge),
		.comparator_high(comparator_high), .sample_enable(sample_enable),
		.sar_trial(sar_trial), .booster_enable(booster_enable),
		.channel_code(channel_code), .digital_input_enable(digital_input_enable),
		.conversion_busy(conversion_busy),
		.conversion_end_irq(conversion_end_irq),
		.conversion_result(conversion_result));
	amc_analog_model i_amc_analog_model (.sys_clk(sys_clk), .vin(vin),
		.sample_enable(sample_enable), .channel_code(channel_code),
		.sar_trial(sar_trial), .comparator_high(comparator_high));
	// ****************************************************
	// Helpers
	// ****************************************************
	function automatic logic [31:0] lfsr_next(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] din_exp(logic [3:0] n);
		return ~8'(9'h001 << n);
	endfunction
	task automatic chk(string name, logic [15:0] sv, logic [15:0] ev);
		tests_run++;
		if (sv !== ev) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", name, ev, sv);
		end
	endtask
	task automatic wr(logic [15:0] a, logic [7:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(logic [15:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic count_irq(int n, output int cn);
		cn = 0;
		repeat (n) begin
			@(posedge sys_clk);
			#1;
			if (conversion_end_irq === 1'b1) cn++;
		end
	endtask
	task automatic wait_irq();
		for (int i = 0; i < 700; i++) begin
			@(posedge sys_clk);
			#1;
			if (conversion_end_irq === 1'b1) return;
		end
		n_mismatch++;
		complete_run();
	endtask
	task automatic edge_pass(logic [5:0] v);
		@(posedge sys_clk);
		ext_irq_input <= v;
		seen = 6'h00;
		repeat (8) begin
			@(posedge sys_clk);
			#1;
			seen |= ext_irq_edge;
		end
	endtask
	task automatic complete_run();
		if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// ****************************************************
	// Main sequence
	// ****************************************************
	initial begin
		{rst_n, reg_write, reg_read, external_conv_trigger} = 4'h0;
		{reg_addr, reg_wdata, ext_irq_input} = '0;
		lfsr = 32'h75ACC338;
		n_mismatch = 0;
		tests_run = 0;
		for (k = 0; k < 10; k++) begin
			lfsr = lfsr_next(lfsr);
			vin[k] = (k == 0) ? 10'h3FF : lfsr[9:0];
		end
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (k = 0; k < 5; k++) begin
			rd(map[k]);
			chk("reset_value", d, 8'h00);
		end
		chk("din_reset", digital_input_enable, 8'hFE);
		for (k = 0; k < 4; k++) begin
			lfsr = lfsr_next(lfsr);
			e = (k == 0) ? 12'h03F : lfsr[11:0];
			wr(OFS_RISE, {2'b00, e[5:0]});
			wr(OFS_FALL, {2'b11, e[11:6]});
			rd(OFS_FALL);
			chk("fall_rb", d, {2'b00, e[11:6]});
			edge_pass(6'h3F);
			chk("rise_edge", seen, e[5:0]);
			edge_pass(6'h00);
			chk("fall_edge", seen, e[11:6]);
			wr(OFS_RISE, 8'h00);
			wr(OFS_FALL, 8'h00);
		end
		wr(OFS_CHAN, 8'hF9);
		rd(OFS_CHAN);
		chk("chan_rb", d, 8'h09);
		chk("din_ch9", digital_input_enable, 8'hFF);
		wr(OFS_MODE, 8'h01);
		repeat (1400) @(posedge sys_clk);
		for (k = 0; k < 4; k++) begin
			lfsr = lfsr_next(lfsr);
			ch = (k == 0) ? 4'h0 : 4'(lfsr[15:8] % 8'd10);
			wr(OFS_MODE, 8'h01);
			wr(OFS_CHAN, {4'h0, ch});
			repeat (2) @(posedge sys_clk);
			chk("din", digital_input_enable, din_exp(ch));
			wr(OFS_MODE, {2'b10, tc[k], 3'b001});
			rd(OFS_MODE);
			chk("mode_rb", d, {2'b10, tc[k], 3'b001});
			wait_irq();
			wait_irq();
			chk("result", conversion_result, vin[ch]);
			rd(OFS_RES_HI);
			chk("res_hi", d, vin[ch][9:2]);
			rd(OFS_RES_LO);
			chk("res_lo", d, {vin[ch][1:0], 6'h00});
			rd(OFS_STATUS);
			chk("status", d, 8'h01);
		end
		repeat (50) @(posedge sys_clk);
		wr(OFS_CHAN, 8'h05);
		wait_irq();
		chk("switch", conversion_result, vin[5]);
		repeat (50) @(posedge sys_clk);
		wr(OFS_MODE, 8'h01);
		count_irq(800, c);
		chk("stopped", c, 0);
		wr(OFS_MODE, 8'h00);
		#1;
		chk("boost_off", booster_enable, 1'b0);
		wr(OFS_MODE, 8'h01);
		repeat (1400) @(posedge sys_clk);
		for (k = 0; k < 4; k++) begin
			wr(OFS_MODE, {5'b11000, 2'(k), 1'b1});
			@(posedge sys_clk);
			external_conv_trigger <= 1'b1;
			count_irq(300, c);
			chk("hw_rise", c, k[1]);
			@(posedge sys_clk);
			external_conv_trigger <= 1'b0;
			count_irq(300, c);
			chk("hw_fall", c, k[0]);
		end
		complete_run();
	end
endmodule
`default_nettype wire
